// ### rtl/preamble_detector.sv
`timescale 1ns/1ps
module preamble_detector
    import preamble_pkg::*;
(
    input  wire logic              pclk,
    input  wire logic              presetn,
    input  wire logic [ADDR_W-1:0] paddr,
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [31:0]       pwdata,
    output logic [31:0]            prdata,
    output logic                   pready,
    output logic                   pslverr,
    input  wire logic              rx_start,
    input  wire logic              rx_stop,
    input  wire logic              sync_done,
    input  wire logic              bit_valid,
    input  wire logic              bit_in,
    input  wire logic              jump_event,
    output logic                   preamble_valid,
    output logic                   sync_search_en,
    output logic                   afc_oneshot,
    output logic                   freq_est_en,
    output logic                   jump_det_hold,
    output logic                   irq
);

    // ----------------------------------------------------------------
    // registers and state
    // ----------------------------------------------------------------
    logic [CTRL_W-1:0] ctrl_r;
    logic [6:0]        thresh_r;
    logic [31:0]       pattern_r;
    logic [4:0]        cus_len_r;
    logic [INT_W-1:0]  istat_r;
    logic [INT_W-1:0]  imask_r;
    logic [INT_W-1:0]  int_set;
    st_e               st_r;
    st_e               st_nxt;
    logic [31:0]       shift_r;
    logic [5:0]        seen_r;
    logic              match_r;
    logic              armed_r;
    logic [RUN_W-1:0]  run;
    logic              last_bit;
    logic              run_clr;
    logic              wr_en;
    logic              std_hit;
    logic              cus_hit;
    logic              arr_hit;
    logic              detect;
    logic [6:0]        arr_need;

    assign wr_en = psel && penable && pwrite && pready;

    // ----------------------------------------------------------------
    // apb slave: one wait-free access phase, registered answer
    // ----------------------------------------------------------------
    function automatic logic mapped(input logic [ADDR_W-1:0] a);
        mapped = (a == CTRL_ADDR) || (a == THRESH_ADDR) || (a == PATTERN_ADDR) ||
                 (a == CUSTOM_ADDR) || (a == STATUS_ADDR) || (a == ISTAT_ADDR) ||
                 (a == IMASK_ADDR);
    endfunction

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end
        else
        begin
            pready  <= psel && !penable;
            pslverr <= psel && !penable && !mapped(paddr);
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            prdata <= '0;
        else if (psel && !penable && !pwrite)
        begin
            case (paddr)
                CTRL_ADDR:    prdata <= {25'h0, ctrl_r};
                THRESH_ADDR:  prdata <= {25'h0, thresh_r};
                PATTERN_ADDR: prdata <= pattern_r;
                CUSTOM_ADDR:  prdata <= {27'h0, cus_len_r};
                STATUS_ADDR:  prdata <= {21'h0, run, jump_det_hold, preamble_valid, st_r};
                ISTAT_ADDR:   prdata <= {29'h0, istat_r};
                IMASK_ADDR:   prdata <= {29'h0, imask_r};
                default:      prdata <= '0;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ctrl_r    <= CTRL_RST;
            thresh_r  <= THRESH_RST;
            pattern_r <= PATTERN_RST;
            cus_len_r <= CUS_LEN_RST;
            imask_r   <= '0;
        end
        else if (wr_en)
        begin
            case (paddr)
                CTRL_ADDR:    ctrl_r    <= pwdata[CTRL_W-1:0];
                THRESH_ADDR:  thresh_r  <= pwdata[6:0];
                PATTERN_ADDR: pattern_r <= pwdata;
                CUSTOM_ADDR:  cus_len_r <= pwdata[4:0];
                IMASK_ADDR:   imask_r   <= pwdata[INT_W-1:0];
                default:      ;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // interrupts: set wins over a same-cycle write-one clear
    // ----------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            istat_r <= '0;
        else if (wr_en && paddr == ISTAT_ADDR)
            istat_r <= (istat_r & ~pwdata[INT_W-1:0]) | int_set;
        else
            istat_r <= istat_r | int_set;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            irq <= 1'b0;
        else
            irq <= |(istat_r & imask_r);
    end

    // ----------------------------------------------------------------
    // detectors
    // ----------------------------------------------------------------
    // a jump while the host owns the jump detector must not re-arm arrival sensing
    assign run_clr = rx_start || (st_r == ST_HUNT && ctrl_r[C_ARRIVAL] && jump_event
                     && !armed_r && !jump_det_hold);

    alt_run_counter #(.W(RUN_W)) alt_run_counter_inst (
        .pclk      (pclk),
        .presetn   (presetn),
        .clr       (run_clr),
        .bit_valid (bit_valid),
        .bit_in    (bit_in),
        .run       (run),
        .last_bit  (last_bit)
    );

    assign arr_need = ctrl_r[C_AFC] ? ARR_AFC_BITS : ARRIVAL_BITS;
    assign std_hit  = !ctrl_r[C_CUSTOM] && (run >= thresh_r);
    assign cus_hit  = ctrl_r[C_CUSTOM] && match_r;
    assign arr_hit  = armed_r && (run >= arr_need);
    assign detect   = ctrl_r[C_ARRIVAL] ? arr_hit : (std_hit || cus_hit);

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            armed_r <= 1'b0;
        else if (st_r != ST_HUNT || !ctrl_r[C_ARRIVAL])
            armed_r <= 1'b0;
        else if (jump_event && !jump_det_hold)
            armed_r <= 1'b1;
    end

    // custom pattern: last len+1 bits must equal the pattern, no run threshold
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            shift_r <= '0;
            seen_r  <= '0;
            match_r <= 1'b0;
        end
        else if (rx_start)
        begin
            shift_r <= '0;
            seen_r  <= '0;
            match_r <= 1'b0;
        end
        else if (bit_valid)
        begin
            shift_r <= {shift_r[30:0], bit_in};
            seen_r  <= (seen_r[5]) ? seen_r : seen_r + 6'h01;
            match_r <= (seen_r >= {1'b0, cus_len_r}) &&
                       ((({shift_r[30:0], bit_in} ^ pattern_r) &
                         ~(32'hffff_fffe << cus_len_r)) == '0);
        end
    end

    // ----------------------------------------------------------------
    // receive sequencing
    // ----------------------------------------------------------------
    always_comb
    begin
        st_nxt = st_r;
        case (st_r)
            ST_IDLE:
                if (rx_start && ctrl_r[C_ENABLE])
                    st_nxt = ST_HUNT;
            ST_HUNT:
                if (!ctrl_r[C_ENABLE])
                    st_nxt = ST_IDLE;
                else if (ctrl_r[C_SKIP] || detect)
                    st_nxt = ST_QUAL;
            ST_QUAL:
                if (rx_start)
                    st_nxt = ST_HUNT;
                else if (sync_done || !ctrl_r[C_ENABLE])
                    st_nxt = ST_IDLE;
            default:
                st_nxt = ST_IDLE;
        endcase
        if (rx_stop)
            st_nxt = ST_IDLE;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            st_r <= ST_IDLE;
        else
            st_r <= st_nxt;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            preamble_valid <= 1'b0;
            sync_search_en <= 1'b0;
        end
        else
        begin
            preamble_valid <= (st_nxt == ST_QUAL) && !(st_r == ST_HUNT && ctrl_r[C_SKIP]
                              && !detect) && !(st_r == ST_QUAL && !preamble_valid);
            sync_search_en <= (st_nxt == ST_QUAL);
        end
    end

    assign int_set[I_PREAMBLE] = (st_r == ST_HUNT) && (st_nxt == ST_QUAL) && detect;
    assign int_set[I_ARRIVAL]  = int_set[I_PREAMBLE] && ctrl_r[C_ARRIVAL];
    assign int_set[I_RECONFIG] = int_set[I_ARRIVAL] && ctrl_r[C_SHARED];

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            afc_oneshot <= 1'b0;
        else
            afc_oneshot <= int_set[I_ARRIVAL] && ctrl_r[C_AFC];
    end

    // jump detector stays with collision sensing until software rewrites control
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            jump_det_hold <= 1'b0;
        else if (int_set[I_RECONFIG])
            jump_det_hold <= 1'b1;
        else if (wr_en && paddr == CTRL_ADDR)
            jump_det_hold <= 1'b0;
    end

    // sync demodulator estimator only has a usable input once alternation is seen
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            freq_est_en <= 1'b0;
        else
            freq_est_en <= ctrl_r[C_ASYNC] || (run >= FE_MIN_RUN);
    end

    // ----------------------------------------------------------------
    // assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    a_sync_gated: assert property (sync_search_en && !ctrl_r[C_SKIP] && $stable(ctrl_r)
        |-> preamble_valid) else $error("sync search without preamble");
    a_std_thresh: assert property (st_r == ST_HUNT && ctrl_r[C_ENABLE] && !rx_stop
        && !ctrl_r[C_ARRIVAL] && !ctrl_r[C_CUSTOM] && run >= thresh_r
        |=> preamble_valid) else $error("threshold reached but no preamble");
    a_std_early: assert property ($rose(preamble_valid) && !$past(ctrl_r[C_ARRIVAL])
        && !$past(ctrl_r[C_CUSTOM]) |-> $past(run) >= $past(thresh_r))
        else $error("preamble before threshold");
    a_arr_byte: assert property (st_r == ST_HUNT && ctrl_r[C_ENABLE] && !rx_stop
        && ctrl_r[C_ARRIVAL] && armed_r && !ctrl_r[C_AFC] && run >= ARRIVAL_BITS
        |=> preamble_valid) else $error("arrival missed after one byte");
    a_afc_settle: assert property (afc_oneshot |-> preamble_valid
        && $past(run) >= ARR_AFC_BITS ##1 !afc_oneshot)
        else $error("correction pulse wrong");
    a_jump_hold: assert property ($rose(jump_det_hold) |-> preamble_valid
        && $past(ctrl_r[C_SHARED]) && istat_r[I_RECONFIG])
        else $error("jump hold without shared detection");
    a_trad_only: assert property (!ctrl_r[C_ARRIVAL] |=> !armed_r)
        else $error("arrival armed in threshold mode");
    a_run_break: assert property (bit_valid && !run_clr && run != '0
        && bit_in == last_bit |=> run == 7'h01) else $error("run not restarted");
    a_run_entry: assert property (rx_start |=> run == '0)
        else $error("run kept over receive entry");
    a_custom_zero: assert property (st_r == ST_HUNT && ctrl_r[C_ENABLE] && !rx_stop
        && !ctrl_r[C_ARRIVAL] && ctrl_r[C_CUSTOM] && match_r
        |=> preamble_valid) else $error("custom match ignored");
    a_fe_async: assert property (ctrl_r[C_ASYNC] |=> freq_est_en)
        else $error("async estimator off");
    a_irq_level: assert property (|(istat_r & imask_r) |=> irq)
        else $error("interrupt not raised");
    a_irq_clear: assert property (!(|(istat_r & imask_r)) |=> !irq)
        else $error("interrupt without unmasked event");
    a_skip_sync: assert property (st_r == ST_HUNT && ctrl_r[C_ENABLE] && !rx_stop
        && ctrl_r[C_SKIP] |=> sync_search_en) else $error("skip mode kept sync search shut");
    // early-detection checks look one cycle back, where the detector made its decision
    a_arr_early: assert property ($rose(preamble_valid) && $past(ctrl_r[C_ARRIVAL])
        |-> $past(armed_r) && $past(run) >= ARRIVAL_BITS)
        else $error("arrival before one byte");
    a_arr_afc: assert property (st_r == ST_HUNT && ctrl_r[C_ENABLE] && !rx_stop
        && ctrl_r[C_ARRIVAL] && armed_r && ctrl_r[C_AFC] && run >= ARR_AFC_BITS
        |=> preamble_valid && afc_oneshot) else $error("arrival with correction missed");
    a_cus_early: assert property ($rose(preamble_valid) && $past(ctrl_r[C_CUSTOM])
        && !$past(ctrl_r[C_ARRIVAL]) |-> $past(match_r))
        else $error("custom preamble without pattern match");
    a_hold_block: assert property (jump_det_hold && !armed_r |=> !armed_r)
        else $error("jump rearmed while detector held");

    c_skip:       cover property (sync_search_en && !preamble_valid);
    c_std_detect: cover property (!ctrl_r[C_ARRIVAL] && $rose(preamble_valid));
    c_arr_afc:    cover property (afc_oneshot);
    c_custom:     cover property (ctrl_r[C_CUSTOM] && $rose(preamble_valid));
    c_hold:       cover property ($rose(jump_det_hold));

endmodule

// ### shared/preamble_pkg.sv
package preamble_pkg;

    // ----------------------------------------------------------------
    // register map
    // ----------------------------------------------------------------
    localparam int          ADDR_W       = 12;
    localparam logic [11:0] CTRL_ADDR    = 12'h000;
    localparam logic [11:0] THRESH_ADDR  = 12'h004;
    localparam logic [11:0] PATTERN_ADDR = 12'h008;
    localparam logic [11:0] CUSTOM_ADDR  = 12'h00c;
    localparam logic [11:0] STATUS_ADDR  = 12'h010;
    localparam logic [11:0] ISTAT_ADDR   = 12'h014;
    localparam logic [11:0] IMASK_ADDR   = 12'h018;

    // ----------------------------------------------------------------
    // control fields
    // ----------------------------------------------------------------
    localparam int C_ENABLE  = 0;
    localparam int C_ARRIVAL = 1;
    localparam int C_CUSTOM  = 2;
    localparam int C_AFC     = 3;
    localparam int C_ASYNC   = 4;
    localparam int C_SKIP    = 5;
    localparam int C_SHARED  = 6;
    localparam int CTRL_W    = 7;

    // ----------------------------------------------------------------
    // interrupt and status fields
    // ----------------------------------------------------------------
    localparam int I_PREAMBLE = 0;
    localparam int I_ARRIVAL  = 1;
    localparam int I_RECONFIG = 2;
    localparam int INT_W      = 3;
    localparam int S_STATE    = 0;
    localparam int S_VALID    = 2;
    localparam int S_HOLD     = 3;
    localparam int S_RUN      = 4;

    // ----------------------------------------------------------------
    // reset values and counts
    // ----------------------------------------------------------------
    localparam logic [6:0]  THRESH_RST   = 7'h14;
    localparam logic [6:0]  CTRL_RST     = 7'h01;
    localparam logic [31:0] PATTERN_RST  = 32'haaaa_aaaa;
    localparam logic [4:0]  CUS_LEN_RST  = 5'h07;
    localparam int          RUN_W        = 7;
    localparam logic [6:0]  ARRIVAL_BITS = 7'h08;
    localparam logic [6:0]  ARR_AFC_BITS = 7'h10;
    localparam logic [6:0]  FE_MIN_RUN   = 7'h02;

    typedef enum logic [1:0] {ST_IDLE, ST_HUNT, ST_QUAL} st_e;

endpackage

// ### rtl/alt_run_counter.sv
`timescale 1ns/1ps
module alt_run_counter
    import preamble_pkg::*;
#(
    parameter int W = RUN_W
)
(
    input  wire logic         pclk,
    input  wire logic         presetn,
    input  wire logic         clr,
    input  wire logic         bit_valid,
    input  wire logic         bit_in,
    output logic [W-1:0]      run,
    output logic              last_bit
);

    // ----------------------------------------------------------------
    // consecutive alternating bit run, saturating
    // ----------------------------------------------------------------
    logic [W-1:0] run_nxt;

    always_comb
    begin
        run_nxt = run;
        if (clr)
            run_nxt = '0;
        else if (bit_valid)
        begin
            if (run == '0)
                run_nxt = {{(W-1){1'b0}}, 1'b1};
            else if (bit_in != last_bit)
                run_nxt = (&run) ? run : run + {{(W-1){1'b0}}, 1'b1};
            else
                run_nxt = {{(W-1){1'b0}}, 1'b1};
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            run <= '0;
        else
            run <= run_nxt;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            last_bit <= 1'b0;
        else if (bit_valid && !clr)
            last_bit <= bit_in;
    end

endmodule

// ### tb/remote_tx.sv
`timescale 1ns/1ps
// ----------------------------------------------------------------
// far-side transmitter model
// ----------------------------------------------------------------
module remote_tx
(
    input  wire logic pclk,
    output logic      bit_valid,
    output logic      bit_in,
    output logic      jump_event
);
    initial
    begin
        bit_valid  = 1'b0;
        bit_in     = 1'b0;
        jump_event = 1'b0;
    end

    // msb of the n-bit slice goes out first; gap idles between bits (slow sender)
    // preamble length is the caller's choice, so keeping it above threshold is on the scenario
    task automatic send(input logic [31:0] word, input int n, input int gap);
        for (int i = n - 1; i >= 0; i--)
        begin
            @(posedge pclk);
            bit_valid <= 1'b1;
            bit_in    <= word[i];
            for (int g = 0; g < gap; g++)
            begin
                @(posedge pclk);
                bit_valid <= 1'b0;
                bit_in    <= ~word[i]; // released line must not look like the last bit
            end
        end
        @(posedge pclk);
        bit_valid <= 1'b0;
        bit_in    <= ~word[0];
    endtask

    task automatic jump();
        @(posedge pclk);
        jump_event <= 1'b1;
        @(posedge pclk);
        jump_event <= 1'b0;
    endtask
endmodule

// ### tb/preamble_detector_tb.sv
`timescale 1ns/1ps
module preamble_detector_tb
    import preamble_pkg::*;
;
    localparam logic [31:0] ONE = 32'h0000_0001;
    localparam logic [31:0] EN  = ONE << C_ENABLE;
    localparam logic [31:0] ARR = ONE << C_ARRIVAL;
    localparam logic [31:0] CUS = ONE << C_CUSTOM;
    localparam logic [31:0] AFC = ONE << C_AFC;
    localparam logic [31:0] ASY = ONE << C_ASYNC;
    localparam logic [31:0] SHR = ONE << C_SHARED;
    localparam logic [31:0] SKP = ONE << C_SKIP;
    localparam logic [31:0] ALT = 32'haaaa_aaaa;

    logic              pclk, presetn, psel, penable, pwrite, pready, pslverr, rd_err;
    logic [ADDR_W-1:0] paddr;
    logic [31:0]       pwdata, prdata, rd_q;
    logic              rx_start, rx_stop, sync_done, bit_valid, bit_in, jump_event;
    logic              preamble_valid, sync_search_en, afc_oneshot, freq_est_en, jump_det_hold, irq;
    int                err_total, checks_done;
    int                afc_pulses = 0;

    preamble_detector preamble_detector_inst (.pclk(pclk), .presetn(presetn), .paddr(paddr),
        .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .rx_start(rx_start), .rx_stop(rx_stop),
        .sync_done(sync_done), .bit_valid(bit_valid), .bit_in(bit_in),
        .jump_event(jump_event), .preamble_valid(preamble_valid),
        .sync_search_en(sync_search_en), .afc_oneshot(afc_oneshot),
        .freq_est_en(freq_est_en), .jump_det_hold(jump_det_hold), .irq(irq));

    remote_tx remote_tx_inst (.pclk(pclk), .bit_valid(bit_valid), .bit_in(bit_in),
        .jump_event(jump_event));

    always #10 pclk = ~pclk;

    // counts high cycles, so a stretched pulse shows up as more than one
    always @(posedge pclk)
    begin
        if (afc_oneshot === 1'b1)
            afc_pulses <= afc_pulses + 1;
    end

    // ----------------------------------------------------------------
    // shared tasks
    // ----------------------------------------------------------------
    task automatic give_verdict();
        $display("checks %0d errors %0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp)
        begin
            err_total++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge pclk);
        psel    <= 1'b1;
        paddr   <= a;
        pwrite  <= w;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do
        begin
            @(posedge pclk);
            n++;
        end
        while (pready !== 1'b1 && n < 16);
        rd_q    = prdata;
        rd_err  = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        if (n >= 16)
            err_total++;
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        apb(a, 1'b1, d);
    endtask

    task automatic rchk(input logic [11:0] a, input logic [31:0] exp);
        apb(a, 1'b0, 32'h0000_0000);
        chk(rd_q, exp);
    endtask

    // order is start, stop, done
    task automatic pulse(input logic [2:0] v);
        @(posedge pclk);
        {rx_start, rx_stop, sync_done} <= v;
        @(posedge pclk);
        {rx_start, rx_stop, sync_done} <= 3'b000;
    endtask

    task automatic wait_valid(input logic exp);
        int n;
        n = 0;
        do
        begin
            @(posedge pclk);
            n++;
        end
        while (preamble_valid !== 1'b1 && n < 6);
        chk(preamble_valid, exp);
    endtask

    // ----------------------------------------------------------------
    // scenarios
    // ----------------------------------------------------------------
    task automatic t_regs();
        rchk(CTRL_ADDR, 32'(CTRL_RST));
        rchk(THRESH_ADDR, 32'(THRESH_RST));
        rchk(PATTERN_ADDR, PATTERN_RST);
        rchk(CUSTOM_ADDR, 32'(CUS_LEN_RST));
        rchk(12'h01c, 32'h0000_0000);
        chk(rd_err, 1);
    endtask

    task automatic t_standard();
        wr(THRESH_ADDR, 32'h0000_0006);
        wr(IMASK_ADDR, ONE << I_PREAMBLE);
        pulse(3'b100);
        remote_tx_inst.send(ALT, 5, 0);
        wait_valid(1'b0);
        chk(sync_search_en, 0);
        chk(freq_est_en, 1);
        remote_tx_inst.send(ONE, 1, 1);
        wait_valid(1'b1);
        chk(sync_search_en, 1);
        repeat (2) @(posedge pclk);
        chk(irq, 1);
        rchk(ISTAT_ADDR, ONE << I_PREAMBLE);
        wr(ISTAT_ADDR, ONE << I_PREAMBLE);
        repeat (2) @(posedge pclk);
        chk(irq, 0);
        pulse(3'b001);
        repeat (2) @(posedge pclk);
        chk(preamble_valid, 0);
    endtask

    task automatic t_break();
        pulse(3'b100);
        apb(STATUS_ADDR, 1'b0, 32'h0000_0000);
        chk(rd_q[S_RUN+:7], 0);
        chk(freq_est_en, 0);
        remote_tx_inst.send(32'h0000_0014, 5, 0);
        apb(STATUS_ADDR, 1'b0, 32'h0000_0000);
        chk(rd_q[S_RUN+:7], 1);
        remote_tx_inst.send(ALT, 4, 0);
        wait_valid(1'b0);
    endtask

    task automatic t_arrival(input logic [31:0] extra, input int nb);
        int p0;
        p0 = afc_pulses;
        wr(CTRL_ADDR, EN | ARR | extra);
        pulse(3'b100);
        remote_tx_inst.send(ALT, nb, 0);
        wait_valid(1'b0);
        remote_tx_inst.jump();
        remote_tx_inst.send(ALT, nb - 1, 0);
        wait_valid(1'b0);
        remote_tx_inst.send(ONE, 1, 0);
        wait_valid(1'b1);
        @(posedge pclk);
        chk(afc_pulses - p0, (extra & AFC) != 0);
    endtask

    task automatic t_shared();
        wr(IMASK_ADDR, ONE << I_RECONFIG);
        t_arrival(SHR, 8);
        repeat (2) @(posedge pclk);
        chk(jump_det_hold, 1);
        chk(irq, 1);
        apb(ISTAT_ADDR, 1'b0, 32'h0000_0000);
        chk(rd_q, (ONE << I_PREAMBLE) | (ONE << I_ARRIVAL) | (ONE << I_RECONFIG));
        wr(CTRL_ADDR, EN | ARR | SHR);
        wr(ISTAT_ADDR, 32'h0000_0007);
        chk(jump_det_hold, 0);
        // irq follows the cleared status one cycle late
        repeat (2) @(posedge pclk);
        chk(irq, 0);
    endtask

    task automatic t_custom();
        wr(THRESH_ADDR, 32'h0000_007f);
        wr(PATTERN_ADDR, 32'h0000_00cc);
        wr(CTRL_ADDR, EN | CUS | ASY);
        pulse(3'b100);
        repeat (2) @(posedge pclk);
        chk(freq_est_en, 1);
        remote_tx_inst.send(32'h0000_0066, 7, 0);
        wait_valid(1'b0);
        remote_tx_inst.send(32'h0000_0000, 1, 0);
        wait_valid(1'b1);
        pulse(3'b010);
        repeat (2) @(posedge pclk);
        chk(preamble_valid, 0);
    endtask

    // skip mode opens sync search with no preamble claimed
    task automatic t_skip();
        wr(CTRL_ADDR, EN | SKP);
        pulse(3'b100);
        repeat (2) @(posedge pclk);
        chk(sync_search_en, 1);
        chk(preamble_valid, 0);
        pulse(3'b001);
        repeat (2) @(posedge pclk);
        chk(sync_search_en, 0);
    endtask

    // ----------------------------------------------------------------
    // main sequence and watchdog
    // ----------------------------------------------------------------
    initial
    begin
        {pclk, presetn, psel, penable, pwrite} = 5'b00000;
        {rx_start, rx_stop, sync_done} = 3'b000;
        paddr = '0;
        pwdata = '0;
        err_total = 0;
        checks_done = 0;
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        t_regs();
        t_standard();
        t_break();
        t_arrival(32'h0000_0000, 8);
        t_arrival(AFC, 16);
        t_shared();
        t_custom();
        t_skip();
        give_verdict();
    end

    // whole run is a few hundred cycles; allow ample margin
    initial
    begin
        #400000;
        err_total++;
        give_verdict();
    end
endmodule
